// ==== src/tec_pkg.sv ====
// constants shared by the receive error counter block
package tec_pkg;

  // register offsets, as printed for one channel
  localparam logic [11:0] TEC_OFS_LCV_HIGH   = 12'h900;
  localparam logic [11:0] TEC_OFS_LCV_LOW    = 12'h901;
  localparam logic [11:0] TEC_OFS_FAE_HIGH   = 12'h902;
  localparam logic [11:0] TEC_OFS_FAE_LOW    = 12'h903;
  localparam logic [11:0] TEC_OFS_IRQ_STATUS = 12'h910;
  localparam logic [11:0] TEC_OFS_IRQ_MASK   = 12'h911;

  // widths
  localparam int TEC_ADDR_W = 12;
  localparam int TEC_BYTE_W = 8;
  localparam int TEC_CNT_W  = 16;
  localparam int TEC_IRQ_W  = 4;

  // interrupt status and mask bit positions
  localparam int TEC_BIT_LCV     = 0;
  localparam int TEC_BIT_FAE     = 1;
  localparam int TEC_BIT_LCV_SAT = 2;
  localparam int TEC_BIT_FAE_SAT = 3;

  // reset and limit values
  localparam logic [15:0] TEC_CNT_RESET  = 16'h0000;
  localparam logic [15:0] TEC_CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] TEC_CNT_ONE    = 16'h0001;
  localparam logic [7:0]  TEC_BYTE_RESET = 8'h00;
  localparam logic [3:0]  TEC_IRQ_RESET  = 4'h0;

  // snapshot state of one counter between its two byte reads
  typedef enum logic {TEC_SNAP_IDLE, TEC_SNAP_HELD} tec_snap_t;

endpackage : tec_pkg

// ==== src/tec_cnt_if.sv ====
// interface between the register front end and one error counter
`timescale 1ns/1ps
`default_nettype none
interface tec_cnt_if;
  import tec_pkg::*;
  logic                 event_pulse; // one error seen this cycle
  logic                 rd_high;     // upper byte is being read
  logic                 rd_low;      // lower byte is being read
  logic [TEC_CNT_W-1:0] count;       // live count
  logic [7:0]           snap;        // lower byte caught at upper read
  logic                 held;        // snapshot waits for lower read
  logic                 overflow;    // event dropped at full scale

  modport ctrl (
    output event_pulse, rd_high, rd_low,
    input  count, snap, held, overflow
  );
  modport cnt (
    input  event_pulse, rd_high, rd_low,
    output count, snap, held, overflow
  );
endinterface : tec_cnt_if
`default_nettype wire

// ==== src/tec_err_counter.sv ====
// one 16-bit clear-on-read error counter with a lower-byte snapshot
`timescale 1ns/1ps
`default_nettype none
module tec_err_counter
  import tec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // counter port
  tec_cnt_if.cnt   cp
);

  logic [TEC_CNT_W-1:0] count;
  logic [TEC_CNT_W-1:0] next_count;
  logic [7:0]           snap;
  logic [7:0]           next_snap;
  tec_snap_t            state;
  tec_snap_t            next_state;
  logic [TEC_CNT_W-1:0] base;

  ////////////////////////////////////////////////////////////////////////////
  // next count: an upper or lone lower read restarts from zero, a same-cycle event still counts
  always_comb begin
    base       = count;
    next_snap  = snap;
    next_state = state;
    if (cp.rd_high) begin
      next_snap  = count[7:0];
      next_state = TEC_SNAP_HELD;
      base       = TEC_CNT_RESET;
    end else if (cp.rd_low) begin
      if (state == TEC_SNAP_HELD) begin
        next_state = TEC_SNAP_IDLE;
        next_snap  = TEC_BYTE_RESET;
      end else begin
        base = TEC_CNT_RESET;                  // lone lower read clears too
      end
    end
    // saturate rather than wrap: a wrapped count would read as small
    if (cp.event_pulse && base != TEC_CNT_MAX) begin
      next_count = base + TEC_CNT_ONE;
    end else begin
      next_count = base;
    end
  end

  // registers only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= TEC_CNT_RESET;
      snap  <= TEC_BYTE_RESET;
      state <= TEC_SNAP_IDLE;
    end else begin
      count <= next_count;
      snap  <= next_snap;
      state <= next_state;
    end
  end

  // views for the front end
  assign cp.count    = count;
  assign cp.snap     = snap;
  assign cp.held     = (state == TEC_SNAP_HELD);
  assign cp.overflow = cp.event_pulse && !cp.rd_high && !cp.rd_low
                       && count == TEC_CNT_MAX;

endmodule : tec_err_counter
`default_nettype wire

// ==== src/tec_top.sv ====
// receive error counters: line code violations and framing alignment
//
// How it works
// - count line code violations in 16 bits since the last read
// - upper-byte register shows count bits 15..8, line violations at 0x900
// - lower-byte register shows count bits 7..0, line violations at 0x901
// - reading a counter clears it; later reads show only newer events
// - count framing alignment errors in 16 bits, upper byte at 0x902
// - upper then lower read clears the whole 16-bit count
// - framing alignment lower byte sits at 0x903
//
// The upper read moves the count aside: its lower byte is frozen for the
// lower read and the live counter restarts at once, so no event is lost.
`timescale 1ns/1ps
`default_nettype none
module tec_top
  import tec_pkg::*;
(
  // clock and reset
  input  wire logic                  SYS_CLK,
  input  wire logic                  RESETN,
  // register port
  input  wire logic [TEC_ADDR_W-1:0] ADDR,
  input  wire logic [7:0]            WR_DATA,
  input  wire logic                  WR_EN,
  input  wire logic                  RD_EN,
  output logic      [7:0]            RD_DATA,
  // events from the receive framer
  input  wire logic                  LINE_VIOLATION_EVENT,
  input  wire logic                  FRAME_ALIGN_ERROR_EVENT,
  // interrupt
  output logic                       IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode shared by read and write paths
  function automatic logic hit(input logic [TEC_ADDR_W-1:0] a,
                               input logic [TEC_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  tec_cnt_if lcv_if ();
  tec_cnt_if fae_if ();

  logic [TEC_IRQ_W-1:0] status;
  logic [TEC_IRQ_W-1:0] next_status;
  logic [TEC_IRQ_W-1:0] mask;
  logic [TEC_IRQ_W-1:0] next_mask;
  logic [TEC_IRQ_W-1:0] events;
  logic                 next_irq;
  logic [7:0]           next_rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // counters
  assign lcv_if.event_pulse = LINE_VIOLATION_EVENT;
  assign lcv_if.rd_high     = RD_EN && hit(ADDR, TEC_OFS_LCV_HIGH);
  assign lcv_if.rd_low      = RD_EN && hit(ADDR, TEC_OFS_LCV_LOW);
  assign fae_if.event_pulse = FRAME_ALIGN_ERROR_EVENT;
  assign fae_if.rd_high     = RD_EN && hit(ADDR, TEC_OFS_FAE_HIGH);
  assign fae_if.rd_low      = RD_EN && hit(ADDR, TEC_OFS_FAE_LOW);

  tec_err_counter u_lcv (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .cp    (lcv_if.cnt)
  );

  tec_err_counter u_fae (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .cp    (fae_if.cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data: valid one cycle after the strobe, zero otherwise
  always_comb begin
    next_rd_data = TEC_BYTE_RESET;
    if (RD_EN) begin
      unique case (1'b1)
        hit(ADDR, TEC_OFS_LCV_HIGH): begin
          next_rd_data = lcv_if.count[15:8];
        end
        hit(ADDR, TEC_OFS_LCV_LOW): begin
          next_rd_data = lcv_if.held ? lcv_if.snap
                                     : lcv_if.count[7:0];
        end
        hit(ADDR, TEC_OFS_FAE_HIGH): begin
          next_rd_data = fae_if.count[15:8];
        end
        hit(ADDR, TEC_OFS_FAE_LOW): begin
          next_rd_data = fae_if.held ? fae_if.snap
                                     : fae_if.count[7:0];
        end
        hit(ADDR, TEC_OFS_IRQ_STATUS): begin
          next_rd_data = {4'h0, status};
        end
        hit(ADDR, TEC_OFS_IRQ_MASK): begin
          next_rd_data = {4'h0, mask};
        end
        default: begin
          next_rd_data = TEC_BYTE_RESET;   // unmapped reads return zero
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RD_DATA <= TEC_BYTE_RESET;
    end else begin
      RD_DATA <= next_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: read clears, but an event in that cycle wins
  always_comb begin
    events                  = '0;
    events[TEC_BIT_LCV]     = LINE_VIOLATION_EVENT;
    events[TEC_BIT_FAE]     = FRAME_ALIGN_ERROR_EVENT;
    events[TEC_BIT_LCV_SAT] = lcv_if.overflow;
    events[TEC_BIT_FAE_SAT] = fae_if.overflow;
    next_status = status;
    if (RD_EN && hit(ADDR, TEC_OFS_IRQ_STATUS)) begin
      next_status = TEC_IRQ_RESET;
    end
    next_status = next_status | events;
    next_mask   = mask;
    if (WR_EN && hit(ADDR, TEC_OFS_IRQ_MASK)) begin
      next_mask = WR_DATA[TEC_IRQ_W-1:0];
    end
    // precompute so the output stays a plain flip-flop
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      status <= TEC_IRQ_RESET;
      mask   <= TEC_IRQ_RESET;
      IRQ    <= 1'b0;
    end else begin
      status <= next_status;
      mask   <= next_mask;
      IRQ    <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  // upper read of the line counter followed at once by its lower read
  sequence s_lcv_high_read;
    RD_EN && ADDR == TEC_OFS_LCV_HIGH;
  endsequence

  sequence s_lcv_pair_quiet;
    s_lcv_high_read ##1 (RD_EN && ADDR == TEC_OFS_LCV_LOW
                         && !LINE_VIOLATION_EVENT);
  endsequence

  sequence s_fae_high_read;
    RD_EN && ADDR == TEC_OFS_FAE_HIGH;
  endsequence

  a_lcv_counts_up: assert property (
    LINE_VIOLATION_EVENT && !lcv_if.rd_high && !lcv_if.rd_low
    && lcv_if.count != TEC_CNT_MAX
    |=> lcv_if.count == $past(lcv_if.count) + TEC_CNT_ONE)
    else $error("line violation not counted");

  a_lcv_high_byte: assert property (
    s_lcv_high_read |=> RD_DATA == $past(lcv_if.count[15:8]))
    else $error("line violation upper byte wrong");

  a_lcv_low_byte: assert property (
    s_lcv_high_read ##1 (RD_EN && ADDR == TEC_OFS_LCV_LOW)
    |=> RD_DATA == $past(lcv_if.count[7:0], 2))
    else $error("line violation lower byte not the snapshot");

  a_read_restarts: assert property (
    s_lcv_high_read |=> lcv_if.count ==
      {15'h0000, $past(LINE_VIOLATION_EVENT)})
    else $error("counter not cleared by read");

  a_fae_counts: assert property (
    s_fae_high_read ##1 (FRAME_ALIGN_ERROR_EVENT && !fae_if.rd_high)
    |=> fae_if.count ==
      {15'h0000, $past(FRAME_ALIGN_ERROR_EVENT, 2)} + TEC_CNT_ONE)
    else $error("framing alignment error not counted");

  a_pair_clears: assert property (
    s_lcv_pair_quiet ##1 (!LINE_VIOLATION_EVENT && !lcv_if.rd_high
                          && !lcv_if.rd_low) [*2]
    |-> lcv_if.count == {15'h0000, $past(LINE_VIOLATION_EVENT, 3)}
        && !lcv_if.held)
    else $error("ordered pair of reads left a count");

  a_fae_low_byte: assert property (
    s_fae_high_read ##1 (RD_EN && ADDR == TEC_OFS_FAE_LOW)
    |=> RD_DATA == $past(fae_if.count[7:0], 2))
    else $error("framing alignment lower byte wrong");

  a_pair_keeps_events: assert property (
    lcv_if.held && lcv_if.rd_low && LINE_VIOLATION_EVENT
    && lcv_if.count != TEC_CNT_MAX
    |=> lcv_if.count == $past(lcv_if.count) + TEC_CNT_ONE)
    else $error("event lost during lower byte read");

  a_irq_follows: assert property (
    (status & mask) != TEC_IRQ_RESET |-> IRQ)
    else $error("interrupt low with unmasked status");

  a_unmapped_zero: assert property (
    RD_EN && ADDR == 12'h0904 |=> RD_DATA == TEC_BYTE_RESET)
    else $error("unmapped read not zero");

endmodule : tec_top
`default_nettype wire

// ==== sim/tec_tb_top.sv ====
// self-checking bench for the receive error counter block
`timescale 1ns/1ps
`default_nettype none
module tec_tb_top;
  import tec_pkg::*;

  logic                  sys_clk;
  logic                  resetn;
  logic [TEC_ADDR_W-1:0] addr;
  logic [7:0]            wr_data;
  logic                  wr_en;
  logic                  rd_en;
  logic [7:0]            rd_data;
  logic                  lcv_ev;
  logic                  fae_ev;
  logic                  irq;
  int                    n_errors;
  int                    tests_run;
  logic [7:0]            got;

  tec_top u_dut (
    .SYS_CLK                 (sys_clk),
    .RESETN                  (resetn),
    .ADDR                    (addr),
    .WR_DATA                 (wr_data),
    .WR_EN                   (wr_en),
    .RD_EN                   (rd_en),
    .RD_DATA                 (rd_data),
    .LINE_VIOLATION_EVENT    (lcv_ev),
    .FRAME_ALIGN_ERROR_EVENT (fae_ev),
    .IRQ                     (irq)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock at 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // compare tasks, one per kind of result
  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] act);
    tests_run++;
    if (act !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, act);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic act);
    tests_run++;
    if (act !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, act);
    end
  endtask : chk1

  ////////////////////////////////////////////////////////////////////////
  // bus cycles: strobes change just after an edge, data sampled settled
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en   <= 1'b0;
  endtask : wr

  // n back-to-back event cycles on one framer line
  task automatic pulse(input bit fae, input int n);
    @(posedge sys_clk);
    if (fae) fae_ev <= 1'b1;
    else lcv_ev <= 1'b1;
    repeat (n) @(posedge sys_clk);
    lcv_ev <= 1'b0;
    fae_ev <= 1'b0;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_values();
    rd(TEC_OFS_LCV_HIGH, got);
    chk8("lcv hi", 8'h00, got);
    rd(TEC_OFS_LCV_LOW, got);
    chk8("lcv lo", 8'h00, got);
    rd(TEC_OFS_FAE_HIGH, got);
    chk8("fae hi", 8'h00, got);
    rd(TEC_OFS_FAE_LOW, got);
    chk8("fae lo", 8'h00, got);
    rd(TEC_OFS_IRQ_MASK, got);
    chk8("mask", 8'h00, got);
    rd(12'h0AB, got);
    chk8("unmapped", 8'h00, got);
    chk1("irq idle", 1'b0, irq);
  endtask : t_reset_values

  task automatic t_line_count();
    pulse(1'b0, 5);
    rd(TEC_OFS_LCV_HIGH, got);
    chk8("lcv hi", 8'h00, got);
    rd(TEC_OFS_LCV_LOW, got);
    chk8("lcv lo", 8'h05, got);
    @(posedge sys_clk);
    #1 chk8("rd idle", 8'h00, rd_data);
    rd(TEC_OFS_LCV_HIGH, got);
    chk8("lcv hi2", 8'h00, got);
    rd(TEC_OFS_LCV_LOW, got);
    chk8("lcv lo2", 8'h00, got);
  endtask : t_line_count

  // 300 errors span both bytes; one more lands between the byte reads
  task automatic t_frame_count();
    pulse(1'b1, 300);
    rd(TEC_OFS_FAE_HIGH, got);
    chk8("fae hi", 8'h01, got);
    pulse(1'b1, 1);
    rd(TEC_OFS_FAE_LOW, got);
    chk8("fae lo", 8'h2C, got);
    rd(TEC_OFS_FAE_HIGH, got);
    chk8("fae hi2", 8'h00, got);
    rd(TEC_OFS_FAE_LOW, got);
    chk8("fae lo2", 8'h01, got);
  endtask : t_frame_count

  // interrupt raised, cleared by a status read, then masked off
  task automatic t_irq();
    rd(TEC_OFS_IRQ_STATUS, got);
    wr(TEC_OFS_IRQ_MASK, 8'h01);
    wr(TEC_OFS_LCV_HIGH, 8'hFF);
    pulse(1'b0, 1);
    repeat (2) @(posedge sys_clk);
    #1 chk1("irq set", 1'b1, irq);
    rd(TEC_OFS_IRQ_STATUS, got);
    chk8("status", 8'h01, got);
    repeat (2) @(posedge sys_clk);
    #1 chk1("irq clear", 1'b0, irq);
    rd(TEC_OFS_IRQ_MASK, got);
    chk8("mask rb", 8'h01, got);
    wr(TEC_OFS_IRQ_MASK, 8'h02);
    pulse(1'b0, 1);
    repeat (2) @(posedge sys_clk);
    #1 chk1("irq masked", 1'b0, irq);
    rd(TEC_OFS_LCV_HIGH, got);
    chk8("lcv hi3", 8'h00, got);
    rd(TEC_OFS_LCV_LOW, got);
    chk8("lcv lo3", 8'h02, got);
  endtask : t_irq

  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic results();
    $display("errors %0d of %0d comparisons", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // a hang is cut short well beyond the few hundred cycles needed
  initial begin
    #200us;
    n_errors++;
    results();
  end

  // main sequence
  initial begin
    n_errors  = 0;
    tests_run = 0;
    resetn    = 1'b0;
    addr      = '0;
    wr_data   = 8'h00;
    wr_en     = 1'b0;
    rd_en     = 1'b0;
    lcv_ev    = 1'b0;
    fae_ev    = 1'b0;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset_values();
    t_line_count();
    t_frame_count();
    t_irq();
    results();
  end
endmodule : tec_tb_top
`default_nettype wire
